/* hdl/acr_pkg.sv */
// constants and types of the analog control register bank
package acr_pkg;
  // ****************************************
  // bus and register map (register indices)
  // ****************************************
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam logic [15:0] BANK_FIRST_IDX = 16'h2858;
  localparam logic [15:0] BANK_LAST_IDX = 16'h2868;
  localparam logic [15:0] GAIN_IDX = 16'h2858;
  localparam logic [15:0] INTEG_IDX = 16'h285A;
  localparam logic [15:0] BATT_IDX = 16'h285C;
  localparam logic [15:0] KEEP_DEFAULT_IDX = 16'h285F;
  localparam int BANK_DEPTH = 17;
  localparam int OFF_W = 5;
  // ****************************************
  // reset values and writable masks
  // ****************************************
  localparam logic [7:0] GAIN_RESET = 8'h00;
  localparam logic [7:0] INTEG_RESET = 8'h00;
  localparam logic [7:0] BATT_RESET = 8'h00;
  localparam logic [7:0] OTHER_RESET = 8'h00;
  localparam logic [7:0] GAIN_MASK = 8'h7F;
  localparam logic [7:0] INTEG_MASK = 8'h0F;
  localparam logic [7:0] BATT_MASK = 8'h09;
  localparam logic [7:0] FULL_MASK = 8'hFF;
  // ****************************************
  // field positions
  // ****************************************
  localparam int VGAIN_BIT = 6;
  localparam int BGAIN_LSB = 3;
  localparam int AGAIN_LSB = 0;
  localparam int INT_M_BIT = 3;
  localparam int INT_U_BIT = 2;
  localparam int INT_B_BIT = 1;
  localparam int INT_A_BIT = 0;
  localparam int BIAS_BIT = 3;
  localparam int DISCH_BIT = 0;
  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {ACR_DUTY_QUARTER, ACR_DUTY_SIXTH, ACR_DUTY_EIGHTH} acr_duty_t;
  typedef struct packed {
    logic voltage_channel_gain_sel;
    logic [2:0] current_b_gain_sel;
    logic [2:0] current_a_gain_sel;
  } acr_gain_t;
  typedef struct packed {
    logic multifunction_integrator_reset;
    logic voltage_integrator_reset;
    logic current_b_integrator_reset;
    logic current_a_integrator_reset;
  } acr_integ_t;
endpackage : acr_pkg

/* hdl/acr_bank.sv */
// apb register bank for analog gain, integrator reset, lcd bias and battery discharge
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - bank decodes indices 0x2858 to 0x2868, read/write
// - every reset source restores all defaults
// - bit 6 picks voltage gain x1/x2
// - bits 5:3 pick channel B gain
// - bits 2:0 pick channel A gain
// - integrator reset bits for M, U, B, A
// - eighth duty: bit 3 picks quarter bias
// - quarter or sixth duty: always third bias
// - bit 0 enables battery discharge
module acr_bank (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [acr_pkg::ADDR_W-1:0] paddr,
  input wire logic [acr_pkg::DATA_W-1:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [acr_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic power_on_reset,
  input wire logic brown_out_reset,
  input wire logic external_reset_pin_n,
  input wire logic watchdog_reset,
  input wire acr_pkg::acr_duty_t lcd_duty_mode,
  output acr_pkg::acr_gain_t gain_sel,
  output logic [2:0] current_a_gain_log2,
  output logic [2:0] current_b_gain_log2,
  output acr_pkg::acr_integ_t integ_reset,
  output logic display_bias_quarter,
  output logic battery_discharge_enable
);

  // ****************************************
  // functions
  // ****************************************
  // gain code to log2 of the factor: x1, x4, x8, x16, x32
  function automatic logic [2:0] gain_log2(input logic [2:0] code);
    logic [2:0] res;
    res = 3'h5;
    case (code)
      3'h0: res = 3'h0;
      3'h1: res = 3'h2;
      3'h2: res = 3'h3;
      3'h3: res = 3'h4;
      default: res = 3'h5;
    endcase
    return res;
  endfunction : gain_log2

  function automatic logic [acr_pkg::OFF_W-1:0] bank_off(input logic [15:0] idx);
    logic [15:0] diff;
    diff = idx - acr_pkg::BANK_FIRST_IDX;
    return diff[acr_pkg::OFF_W-1:0];
  endfunction : bank_off

  // writable bits of each location
  function automatic logic [7:0] wr_mask(input logic [acr_pkg::OFF_W-1:0] off);
    logic [7:0] m;
    m = acr_pkg::FULL_MASK;
    if (off == bank_off(acr_pkg::GAIN_IDX)) begin
      m = acr_pkg::GAIN_MASK;
    end else if (off == bank_off(acr_pkg::INTEG_IDX)) begin
      m = acr_pkg::INTEG_MASK;
    end else if (off == bank_off(acr_pkg::BATT_IDX)) begin
      m = acr_pkg::BATT_MASK;
    end
    return m;
  endfunction : wr_mask

  // ****************************************
  // reset source synchronisers
  // ****************************************
  logic [3:0] rst_meta_reg;
  logic [3:0] rst_sync_reg;
  logic bank_rst;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rst_meta_reg <= 4'h0;
      rst_sync_reg <= 4'h0;
    end else begin
      rst_meta_reg <= {power_on_reset, brown_out_reset, ~external_reset_pin_n, watchdog_reset};
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign bank_rst = srst | (|rst_sync_reg);

  // ****************************************
  // apb decode and answer
  // ****************************************
  logic [15:0] idx;
  logic hit;
  logic [acr_pkg::OFF_W-1:0] off;
  logic wr_fire;
  logic [acr_pkg::DATA_W-1:0] prdata_reg;
  logic [acr_pkg::DATA_W-1:0] prdata_next;
  logic pready_reg;
  logic pready_next;
  logic pslverr_reg;
  logic pslverr_next;
  logic [7:0] mem_reg [acr_pkg::BANK_DEPTH];
  logic [7:0] mem_next [acr_pkg::BANK_DEPTH];

  assign idx = {2'h0, paddr[15:2]};
  assign hit = (paddr[1:0] == 2'h0) && (idx >= acr_pkg::BANK_FIRST_IDX)
               && (idx <= acr_pkg::BANK_LAST_IDX);
  assign off = bank_off(idx);
  assign wr_fire = psel & penable & pready_reg & pwrite & hit & pstrb[0];

  always_comb begin
    pready_next = psel & ~penable;
    pslverr_next = psel & ~penable & ~hit;
    prdata_next = '0;
    if (psel && !penable && hit && !pwrite) begin
      prdata_next = {24'h0, mem_reg[off]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= '0;
    end else begin
      pready_reg <= pready_next;
      pslverr_reg <= pslverr_next;
      prdata_reg <= prdata_next;
    end
  end

  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign prdata = prdata_reg;

  // ****************************************
  // register storage
  // ****************************************
  always_comb begin
    for (int i = 0; i < acr_pkg::BANK_DEPTH; i++) begin
      mem_next[i] = mem_reg[i];
    end
    if (wr_fire) begin
      mem_next[off] = pwdata[7:0] & wr_mask(off);
    end
  end

  // 0x285F is stored like any byte and holds its default unless written
  always_ff @(posedge core_clk) begin
    if (bank_rst) begin
      for (int i = 0; i < acr_pkg::BANK_DEPTH; i++) begin
        mem_reg[i] <= acr_pkg::OTHER_RESET;
      end
      mem_reg[bank_off(acr_pkg::GAIN_IDX)] <= acr_pkg::GAIN_RESET;
      mem_reg[bank_off(acr_pkg::INTEG_IDX)] <= acr_pkg::INTEG_RESET;
      mem_reg[bank_off(acr_pkg::BATT_IDX)] <= acr_pkg::BATT_RESET;
    end else begin
      for (int i = 0; i < acr_pkg::BANK_DEPTH; i++) begin
        mem_reg[i] <= mem_next[i];
      end
    end
  end

  // ****************************************
  // analog control outputs
  // ****************************************
  logic [7:0] gain_byte;
  logic [7:0] integ_byte;
  logic [7:0] batt_byte;
  acr_pkg::acr_gain_t gain_sel_reg;
  acr_pkg::acr_gain_t gain_sel_next;
  logic [2:0] a_log2_reg;
  logic [2:0] a_log2_next;
  logic [2:0] b_log2_reg;
  logic [2:0] b_log2_next;
  acr_pkg::acr_integ_t integ_reg;
  acr_pkg::acr_integ_t integ_next;
  logic bias_reg;
  logic bias_next;
  logic disch_reg;
  logic disch_next;

  assign gain_byte = mem_next[bank_off(acr_pkg::GAIN_IDX)];
  assign integ_byte = mem_next[bank_off(acr_pkg::INTEG_IDX)];
  assign batt_byte = mem_next[bank_off(acr_pkg::BATT_IDX)];

  always_comb begin
    gain_sel_next.voltage_channel_gain_sel = gain_byte[acr_pkg::VGAIN_BIT];
    gain_sel_next.current_b_gain_sel = gain_byte[acr_pkg::BGAIN_LSB +: 3];
    gain_sel_next.current_a_gain_sel = gain_byte[acr_pkg::AGAIN_LSB +: 3];
    b_log2_next = gain_log2(gain_byte[acr_pkg::BGAIN_LSB +: 3]);
    a_log2_next = gain_log2(gain_byte[acr_pkg::AGAIN_LSB +: 3]);
    // stored levels, so a reset stays asserted until cleared
    integ_next.multifunction_integrator_reset = integ_byte[acr_pkg::INT_M_BIT];
    integ_next.voltage_integrator_reset = integ_byte[acr_pkg::INT_U_BIT];
    integ_next.current_b_integrator_reset = integ_byte[acr_pkg::INT_B_BIT];
    integ_next.current_a_integrator_reset = integ_byte[acr_pkg::INT_A_BIT];
    bias_next = 1'b0;
    if (lcd_duty_mode == acr_pkg::ACR_DUTY_EIGHTH) begin
      bias_next = batt_byte[acr_pkg::BIAS_BIT];
    end
    disch_next = batt_byte[acr_pkg::DISCH_BIT];
  end

  always_ff @(posedge core_clk) begin
    if (bank_rst) begin
      gain_sel_reg <= '0;
      a_log2_reg <= 3'h0;
      b_log2_reg <= 3'h0;
      integ_reg <= '0;
      bias_reg <= 1'b0;
      disch_reg <= 1'b0;
    end else begin
      gain_sel_reg <= gain_sel_next;
      a_log2_reg <= a_log2_next;
      b_log2_reg <= b_log2_next;
      integ_reg <= integ_next;
      bias_reg <= bias_next;
      disch_reg <= disch_next;
    end
  end

  assign gain_sel = gain_sel_reg;
  assign current_a_gain_log2 = a_log2_reg;
  assign current_b_gain_log2 = b_log2_reg;
  assign integ_reset = integ_reg;
  assign display_bias_quarter = bias_reg;
  assign battery_discharge_enable = disch_reg;

  // ****************************************
  // assertions
  // ****************************************
  a_range_error: assert property (@(posedge core_clk) disable iff (srst)
    (psel && !penable) |=> (pready && (pslverr == !$past(hit))))
    else $error("error answer does not match address range");

  a_reset_defaults: assert property (@(posedge core_clk)
    $past(bank_rst) |-> (gain_sel == '0 && integ_reset == '0 && !battery_discharge_enable
      && !display_bias_quarter))
    else $error("outputs not at default after reset");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (bank_rst)
    (psel && !penable && !pwrite && hit && idx == acr_pkg::BATT_IDX)
      |=> (prdata[7:0] & ~acr_pkg::BATT_MASK) == 8'h00)
    else $error("reserved bits read nonzero");

  a_volt_gain: assert property (@(posedge core_clk) disable iff (bank_rst)
    (wr_fire && idx == acr_pkg::GAIN_IDX)
      |=> gain_sel.voltage_channel_gain_sel == $past(pwdata[6]))
    else $error("voltage gain select not written");

  a_b_gain_top: assert property (@(posedge core_clk) disable iff (bank_rst)
    gain_sel.current_b_gain_sel[2] |-> current_b_gain_log2 == 3'h5)
    else $error("channel B gain not x32");

  a_a_gain_map: assert property (@(posedge core_clk) disable iff (bank_rst)
    (wr_fire && idx == acr_pkg::GAIN_IDX && pwdata[2:0] == 3'h1)
      |=> (current_a_gain_log2 == 3'h2 && gain_sel.current_a_gain_sel == 3'h1))
    else $error("channel A gain x4 not selected");

  a_integ_write: assert property (@(posedge core_clk) disable iff (bank_rst)
    (wr_fire && idx == acr_pkg::INTEG_IDX) |=> integ_reset == $past(pwdata[3:0]))
    else $error("integrator resets not written");

  a_integ_hold: assert property (@(posedge core_clk) disable iff (bank_rst)
    (integ_reset.voltage_integrator_reset && !(wr_fire && idx == acr_pkg::INTEG_IDX))
      |=> integ_reset.voltage_integrator_reset)
    else $error("integrator reset dropped without write");

  a_bias_eighth: assert property (@(posedge core_clk) disable iff (bank_rst)
    ##1 ($past(lcd_duty_mode) == acr_pkg::ACR_DUTY_EIGHTH)
      |-> display_bias_quarter == mem_reg[bank_off(acr_pkg::BATT_IDX)][3])
    else $error("bias select not applied in eighth duty");

  a_bias_third: assert property (@(posedge core_clk) disable iff (bank_rst)
    (lcd_duty_mode != acr_pkg::ACR_DUTY_EIGHTH) |=> !display_bias_quarter)
    else $error("quarter bias outside eighth duty");

  a_discharge: assert property (@(posedge core_clk) disable iff (bank_rst)
    (wr_fire && idx == acr_pkg::BATT_IDX) |=> battery_discharge_enable == $past(pwdata[0]))
    else $error("discharge enable not written");

  a_gain_write: assert property (@(posedge core_clk) disable iff (bank_rst)
    (wr_fire && idx == acr_pkg::GAIN_IDX) |=> gain_sel == $past(pwdata[6:0]))
    else $error("gain selects not written");

  a_integ_keep: assert property (@(posedge core_clk) disable iff (bank_rst)
    !(wr_fire && idx == acr_pkg::INTEG_IDX) |=> $stable(integ_reset))
    else $error("integrator resets changed without write");

  a_err_nodata: assert property (@(posedge core_clk) disable iff (srst)
    (psel && !penable && !hit) |=> (pslverr && prdata == '0))
    else $error("unmapped access answered with data");

  a_ready_single: assert property (@(posedge core_clk) disable iff (srst)
    (psel && penable && pready) |=> !pready)
    else $error("ready held past one access cycle");

endmodule : acr_bank

/* bench/acr_bank_tb_top.sv */
// self-checking testbench of the analog control register bank
`timescale 1ns/1ps
module acr_bank_tb_top;
  // ****************************************
  // signals and design instance
  // ****************************************
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [15:0] paddr = 16'h0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic power_on_reset = 1'b0;
  logic brown_out_reset = 1'b0;
  logic external_reset_pin_n = 1'b1;
  logic watchdog_reset = 1'b0;
  acr_pkg::acr_duty_t lcd_duty_mode = acr_pkg::ACR_DUTY_QUARTER;
  acr_pkg::acr_gain_t gain_sel;
  logic [2:0] current_a_gain_log2;
  logic [2:0] current_b_gain_log2;
  acr_pkg::acr_integ_t integ_reset;
  logic display_bias_quarter;
  logic battery_discharge_enable;
  int miscompares = 0;
  int cmp_count = 0;
  acr_bank dut (.core_clk(core_clk), .srst(srst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .power_on_reset(power_on_reset),
    .brown_out_reset(brown_out_reset), .external_reset_pin_n(external_reset_pin_n),
    .watchdog_reset(watchdog_reset), .lcd_duty_mode(lcd_duty_mode), .gain_sel(gain_sel),
    .current_a_gain_log2(current_a_gain_log2), .current_b_gain_log2(current_b_gain_log2),
    .integ_reset(integ_reset), .display_bias_quarter(display_bias_quarter),
    .battery_discharge_enable(battery_discharge_enable));
  always #5 core_clk = ~core_clk;
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] ba(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction : ba
  // gain code to log2 of the amplifier gain
  function automatic logic [2:0] glog(input logic [2:0] c);
    case (c)
      3'h0: return 3'h0;
      3'h1: return 3'h2;
      3'h2: return 3'h3;
      3'h3: return 3'h4;
      default: return 3'h5;
    endcase
  endfunction : glog
  task automatic complete_run();
    if (miscompares == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : complete_run
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      $display("unexpected %s expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    // pready, read data and response are taken at the completing rising edge
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      miscompares++;
      complete_run();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wreg(input logic [15:0] a, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, {$urandom} & 32'hFFFF_FF00 | {24'h0, d}, r, e);
  endtask : wreg
  task automatic rreg(input logic [15:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk("prdata", exp, r);
    chk("pslverr", {31'h0, eexp}, {31'h0, e});
  endtask : rreg
  task automatic outs(input logic [7:0] g, input logic [7:0] i, input logic [7:0] b);
    @(negedge core_clk);
    chk("gain_sel", {25'h0, g[6:0]}, {25'h0, gain_sel});
    chk("gain_a", {29'h0, glog(g[2:0])}, {29'h0, current_a_gain_log2});
    chk("gain_b", {29'h0, glog(g[5:3])}, {29'h0, current_b_gain_log2});
    chk("integ_reset", {28'h0, i[3:0]}, {28'h0, integ_reset});
    chk("discharge", {31'h0, b[0]}, {31'h0, battery_discharge_enable});
    chk("bias", {31'h0, b[3] & (lcd_duty_mode == acr_pkg::ACR_DUTY_EIGHTH)},
        {31'h0, display_bias_quarter});
    // hand back on a rising edge so the next input change lands there
    @(posedge core_clk);
  endtask : outs
  task automatic src(input int k, input logic v);
    case (k)
      0: power_on_reset <= v;
      1: brown_out_reset <= v;
      2: watchdog_reset <= v;
      default: external_reset_pin_n <= ~v;
    endcase
  endtask : src
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] g;
    logic [7:0] i;
    logic [7:0] b;
    void'($urandom(32'hB468));
    repeat (12) @(posedge core_clk);
    srst <= 1'b0;
    rreg(ba(acr_pkg::GAIN_IDX), 32'h0, 1'b0);
    rreg(ba(acr_pkg::INTEG_IDX), 32'h0, 1'b0);
    rreg(ba(acr_pkg::BATT_IDX), 32'h0, 1'b0);
    outs(8'h00, 8'h00, 8'h00);
    for (int n = 0; n < 24; n++) begin
      g = $urandom;
      i = $urandom;
      b = $urandom;
      if (n < 8) g[5:0] = {n[2:0], ~n[2:0]};
      else g[5:0] = g[5:0] | 6'h09;
      lcd_duty_mode <= acr_pkg::acr_duty_t'($urandom_range(0, 2));
      wreg(ba(acr_pkg::GAIN_IDX), g);
      wreg(ba(acr_pkg::INTEG_IDX), i);
      wreg(ba(acr_pkg::BATT_IDX), b);
      rreg(ba(acr_pkg::GAIN_IDX), {24'h0, g & 8'h7F}, 1'b0);
      rreg(ba(acr_pkg::INTEG_IDX), {24'h0, i & 8'h0F}, 1'b0);
      rreg(ba(acr_pkg::BATT_IDX), {24'h0, b & 8'h09}, 1'b0);
      outs(g, i, b);
    end
    rreg(ba(acr_pkg::KEEP_DEFAULT_IDX), 32'h0, 1'b0);
    wreg(ba(acr_pkg::INTEG_IDX), 8'h0F);
    repeat (20) @(posedge core_clk);
    outs(g, 8'h0F, b);
    wreg(ba(acr_pkg::INTEG_IDX), 8'h00);
    outs(g, 8'h00, b);
    // eighth duty honours the bias bit, sixth duty forces third bias
    lcd_duty_mode <= acr_pkg::ACR_DUTY_EIGHTH;
    wreg(ba(acr_pkg::BATT_IDX), 8'h08);
    outs(g, 8'h00, 8'h08);
    lcd_duty_mode <= acr_pkg::ACR_DUTY_SIXTH;
    repeat (2) @(posedge core_clk);
    outs(g, 8'h00, 8'h08);
    // other in-range places hold a full byte
    g = $urandom;
    wreg(ba(16'h2868), g);
    rreg(ba(16'h2868), {24'h0, g}, 1'b0);
    wreg(ba(16'h2859), ~g);
    rreg(ba(16'h2859), {24'h0, ~g}, 1'b0);
    // write with the low lane strobe off is dropped
    wreg(ba(acr_pkg::GAIN_IDX), 8'h12);
    pstrb <= 4'hE;
    wreg(ba(acr_pkg::GAIN_IDX), 8'h2D);
    pstrb <= 4'hF;
    rreg(ba(acr_pkg::GAIN_IDX), 32'h12, 1'b0);
    // outside the bank or unaligned: error, no store
    wreg(16'hA161, 8'h3F);
    rreg(ba(16'h2869), 32'h0, 1'b1);
    rreg(ba(16'h2857), 32'h0, 1'b1);
    rreg(16'hA162, 32'h0, 1'b1);
    rreg(ba(acr_pkg::GAIN_IDX), 32'h12, 1'b0);
    // each reset source restores the defaults
    for (int k = 0; k < 5; k++) begin
      wreg(ba(acr_pkg::GAIN_IDX), 8'h5B);
      wreg(ba(acr_pkg::BATT_IDX), 8'h09);
      @(posedge core_clk);
      if (k == 4) srst <= 1'b1;
      else src(k, 1'b1);
      repeat (4) @(posedge core_clk);
      if (k == 4) srst <= 1'b0;
      else src(k, 1'b0);
      repeat (4) @(posedge core_clk);
      rreg(ba(acr_pkg::GAIN_IDX), 32'h0, 1'b0);
      rreg(ba(acr_pkg::BATT_IDX), 32'h0, 1'b0);
      outs(8'h00, 8'h00, 8'h00);
    end
    complete_run();
  end
endmodule : acr_bank_tb_top
